// File: rtl/bkreg_defs.vh
// offsets, field positions, reset values and fuse word indices for the buck register slice
`ifndef BKREG_DEFS_VH
`define BKREG_DEFS_VH

// ============================================================
// register offsets (8-bit register address space)
`define BKREG_ADDR_SLEEP_VOLT   8'h3a
`define BKREG_ADDR_CONTROL      8'h3b
`define BKREG_ADDR_LIMIT_TIMING 8'h3c
`define BKREG_ADDR_BUCK3_VOLT   8'h3e

// ============================================================
// control register field positions
`define BKREG_CTL_RUN_EN        0
`define BKREG_CTL_STBY_EN       1
`define BKREG_CTL_SLEEP_EN      2
`define BKREG_CTL_LOW_POWER     3
`define BKREG_CTL_SLEW          4
`define BKREG_CTL_FORCED_PULSE_WIDTH_RAMP     5
`define BKREG_CTL_FORCED_PULSE_WIDTH          6
`define BKREG_CTL_DISCH_DIS     7

// limit/timing register field positions
`define BKREG_LIM_ILIM_MSB      1
`define BKREG_LIM_ILIM_LSB      0
`define BKREG_LIM_TIMING        4

// ============================================================
// field widths and reset values
`define BKREG_VCODE_W           6
`define BKREG_B3CODE_W          4
`define BKREG_CONTROL_RST       8'h00
`define BKREG_LIMIT_RST         8'h00
`define BKREG_SLEW_FAST_RST     1'b0

// ============================================================
// fuse shadow load sequence: one fuse word per index, three load steps each
`define BKREG_FUSE_WORDS        4
`define BKREG_FUSE_AW           2
`define BKREG_FUSE_SLEEPV       2'h0
`define BKREG_FUSE_CONTROL      2'h1
`define BKREG_FUSE_LIMIT        2'h2
`define BKREG_FUSE_BUCK3V       2'h3

`endif

// File: rtl/bkreg_fuse_rom.v
// small fuse memory with a registered read port, loaded by the fuse programming path
`timescale 1ns/1ps

module bkreg_fuse_rom (
  clk,
  rst_sync_n,
  prog_we,
  prog_addr,
  prog_data,
  rd_addr,
  rd_data
);
  input  wire       clk;        // system clock
  input  wire       rst_sync_n; // synchronised reset, active low
  input  wire       prog_we;    // fuse programming write strobe
  input  wire [1:0] prog_addr;  // fuse word to program
  input  wire [7:0] prog_data;  // fuse word value
  input  wire [1:0] rd_addr;    // fuse word to read
  output reg  [7:0] rd_data;    // registered read data

  // ============================================================
  // storage: no reset so it maps onto a plain memory
  reg [7:0] mem [0:3];

  // programming writes; the array keeps its contents through reset
  always @(posedge clk) begin
    if (prog_we) begin
      mem[prog_addr] <= prog_data;
    end
  end

  // registered read port
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// File: rtl/bkreg_top.v
// buck regulator control register slice with fuse-loaded defaults
`timescale 1ns/1ps
`include "bkreg_defs.vh"

module bkreg_top (
  clk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  fuse_prog_we,
  fuse_prog_addr,
  fuse_prog_data,
  fuse_scaling_select,
  buck2_run_voltage_code,
  mode_standby,
  mode_sleep,
  fuse_load_done,
  buck2_sleep_voltage_code,
  buck2_on,
  buck2_low_power_select,
  buck2_slew_select,
  buck2_forced_pwm_on_ramp_down,
  buck2_forced_pwm,
  buck2_discharge_on,
  buck2_current_limit,
  buck2_timing_method,
  buck3_run_voltage_code
);
  input  wire       clk;                           // 10 MHz system clock
  input  wire       rst_n;                         // asynchronous reset, active low
  input  wire [7:0] reg_addr;                      // register address
  input  wire [7:0] reg_wdata;                     // register write data
  input  wire       reg_wr;                        // write strobe
  input  wire       reg_rd;                        // read strobe
  output reg  [7:0] reg_rdata;                     // read data, one cycle after strobe
  input  wire       fuse_prog_we;                  // fuse programming strobe
  input  wire [1:0] fuse_prog_addr;                // fuse word address
  input  wire [7:0] fuse_prog_data;                // fuse word data
  input  wire       fuse_scaling_select;           // fuse option, pin level
  input  wire [5:0] buck2_run_voltage_code;        // run code from neighbouring slice
  input  wire       mode_standby;                  // device in standby, pin level
  input  wire       mode_sleep;                    // device in sleep, pin level
  output reg        fuse_load_done;                // fuse shadow loading finished
  output reg  [5:0] buck2_sleep_voltage_code;      // sleep voltage to regulator
  output reg        buck2_on;                      // regulator enable for current mode
  output reg        buck2_low_power_select;        // low-power mode request
  output reg        buck2_slew_select;             // effective slew select
  output reg        buck2_forced_pwm_on_ramp_down; // forced pwm while ramping down
  output reg        buck2_forced_pwm;              // forced pwm always
  output reg        buck2_discharge_on;            // discharge resistor connect
  output reg  [1:0] buck2_current_limit;           // current limit code
  output reg        buck2_timing_method;           // 0 on-time, 1 off-time
  output reg  [3:0] buck3_run_voltage_code;        // buck3 run code

  // ============================================================
  // timing overview
  // - reset asserts at once and releases two edges after rst_n rises
  // - the fuse copy then takes three cycles per word, twelve in all
  // - fuse_load_done rises one edge after the last word is taken
  // - register writes are accepted only once fuse_load_done is high,
  //   so a write can never land between two fuse words
  // - reads work from the internal release on and cost no wait state
  // - a write reaches storage at its own edge and the regulator
  //   outputs one edge later; mode pins add two synchroniser edges
  // - enable and discharge are registered from one next value, so
  //   the resistor is never connected while the enable is high

  // ============================================================
  // reset release synchroniser
  // rst_n may rise at any point of the clock period; the two flops
  // make the release land on a clock edge, so no register sees a
  // release too close to its sampling edge
  reg rst_meta_q;  // first stage, read only by the second
  reg rst_sync_q;  // synchronised reset used everywhere else

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ============================================================
  // pin input synchronisers (mode pins and fuse option)
  // these pins come from outside this clock domain; each bit is
  // synchronised alone, which is safe because no logic relies on
  // two of them changing in the same cycle
  reg [2:0] pin_meta_q;  // first stage
  reg [2:0] pin_q;       // second stage: {scaling_select, sleep, standby}

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pin_meta_q <= 3'h0;
      pin_q      <= 3'h0;
    end else begin
      pin_meta_q <= {fuse_scaling_select, mode_sleep, mode_standby};
      pin_q      <= pin_meta_q;
    end
  end

  wire in_standby   = pin_q[0];
  wire in_sleep     = pin_q[1];
  wire scaling_fuse = pin_q[2];

  // ============================================================
  // fuse memory and boot load sequencer
  // the memory read port is registered, so each word needs three
  // steps: present the address, let the read flop capture it, copy.
  // a slower sequencer was traded for a plain memory with no bypass
  localparam [1:0] LD_ISSUE = 2'b00;  // present read address
  localparam [1:0] LD_WAIT  = 2'b01;  // memory read latency
  localparam [1:0] LD_TAKE  = 2'b10;  // copy word into shadow
  localparam [1:0] LD_DONE  = 2'b11;  // normal operation

  reg  [1:0] ld_state_q;  // loader state
  reg  [1:0] ld_idx_q;    // fuse word being loaded
  wire [7:0] fuse_word;   // registered fuse read data

  bkreg_fuse_rom u_fuse (
    .clk        (clk),
    .rst_sync_n (rst_sync_q),
    .prog_we    (fuse_prog_we),
    .prog_addr  (fuse_prog_addr),
    .prog_data  (fuse_prog_data),
    .rd_addr    (ld_idx_q),
    .rd_data    (fuse_word)
  );

  // walk through the fuse words once after each reset
  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ld_state_q <= LD_ISSUE;
      ld_idx_q   <= 2'h0;
    end else begin
      case (ld_state_q)
        LD_ISSUE: begin
          ld_state_q <= LD_WAIT;
        end
        LD_WAIT: begin
          ld_state_q <= LD_TAKE;
        end
        LD_TAKE: begin
          // last word taken: stop, else move on
          if (ld_idx_q == `BKREG_FUSE_WORDS - 1) begin
            ld_state_q <= LD_DONE;
          end else begin
            ld_idx_q   <= ld_idx_q + 2'h1;
            ld_state_q <= LD_ISSUE;
          end
        end
        default: begin
          ld_state_q <= LD_DONE;
        end
      endcase
    end
  end

  wire loading = (ld_state_q == LD_TAKE);
  wire booted  = (ld_state_q == LD_DONE);

  // ============================================================
  // register write decode; writes before fuse_load_done is high are
  // dropped so the fuse defaults cannot be half-overwritten, and the
  // one-off sleep code copy never meets a software write
  function is_write;
    input [7:0] addr;
    input [7:0] target;
    begin
      is_write = reg_wr && fuse_load_done && (addr == target);
    end
  endfunction

  wire wr_sleepv  = is_write(reg_addr, `BKREG_ADDR_SLEEP_VOLT);
  wire wr_control = is_write(reg_addr, `BKREG_ADDR_CONTROL);
  wire wr_limit   = is_write(reg_addr, `BKREG_ADDR_LIMIT_TIMING);
  wire wr_b3volt  = is_write(reg_addr, `BKREG_ADDR_BUCK3_VOLT);

  // ============================================================
  // storage registers
  // unused bits are not stored at all, which makes them read zero
  // and keeps writes to them from reaching the regulator
  // sleepv_fused_q marks that the sleep code holds a real value
  reg [5:0] sleepv_q;   // sleep voltage code
  reg [7:0] control_q;  // buck2 control bits
  reg [1:0] ilim_q;     // current limit
  reg       tmode_q;    // timing method
  reg [3:0] b3volt_q;   // buck3 run code
  reg       sleepv_fused_q;  // sleep code set by a nonzero fuse word, the run code copy or a write

  // shadow registers: fuse words first, software after
  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sleepv_q       <= 6'h00;
      control_q      <= `BKREG_CONTROL_RST;
      ilim_q         <= 2'h0;
      tmode_q        <= 1'b0;
      b3volt_q       <= 4'h0;
      sleepv_fused_q <= 1'b0;
    end else if (loading) begin
      // boot copy from fuses
      case (ld_idx_q)
        `BKREG_FUSE_SLEEPV: begin
          sleepv_q       <= fuse_word[5:0];
          sleepv_fused_q <= (fuse_word != 8'h00);
        end
        `BKREG_FUSE_CONTROL: begin
          control_q <= fuse_word;
        end
        `BKREG_FUSE_LIMIT: begin
          ilim_q  <= fuse_word[`BKREG_LIM_ILIM_MSB:`BKREG_LIM_ILIM_LSB];
          tmode_q <= 1'b0;
        end
        default: begin
          b3volt_q <= fuse_word[3:0];
        end
      endcase
    end else if (ld_state_q == LD_DONE && !sleepv_fused_q && sleepv_q == 6'h00 &&
                 !wr_sleepv) begin
      // blank fuse: take a copy of the run code as the sleep code.
      // the copy happens once, in the first cycle after the load, and
      // a later run code change does not move the sleep code
      sleepv_q <= buck2_run_voltage_code;
      sleepv_fused_q <= 1'b1;
    end else begin
      // unused high bits are dropped on every write
      if (wr_sleepv) begin
        sleepv_q       <= reg_wdata[5:0];
        sleepv_fused_q <= 1'b1;
      end
      if (wr_control) begin
        control_q <= reg_wdata;
      end
      if (wr_limit) begin
        ilim_q  <= reg_wdata[`BKREG_LIM_ILIM_MSB:`BKREG_LIM_ILIM_LSB];
        tmode_q <= reg_wdata[`BKREG_LIM_TIMING];
      end
      if (wr_b3volt) begin
        b3volt_q <= reg_wdata[3:0];
      end
    end
  end

  // ============================================================
  // read data: one cycle after the strobe, zero for unused bits
  // read data returns to zero after its one cycle, so a stale value
  // can never be mistaken for a second read
  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `BKREG_ADDR_SLEEP_VOLT) begin
        reg_rdata <= {2'h0, sleepv_q};
      end else if (reg_addr == `BKREG_ADDR_CONTROL) begin
        reg_rdata <= control_q;
      end else if (reg_addr == `BKREG_ADDR_LIMIT_TIMING) begin
        reg_rdata <= {3'h0, tmode_q, 2'h0, ilim_q};
      end else if (reg_addr == `BKREG_ADDR_BUCK3_VOLT) begin
        reg_rdata <= {4'h0, b3volt_q};
      end else begin
        // unmapped addresses read zero
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ============================================================
  // enable for the present power mode; sleep wins over standby if
  // both pins are high. the discharge control is taken from the same next value,
  // so resistor and enable never overlap, not even for one cycle
  reg buck2_on_d;  // next value of buck2_on

  always @* begin
    if (in_sleep) begin
      buck2_on_d = control_q[`BKREG_CTL_SLEEP_EN];
    end else if (in_standby) begin
      buck2_on_d = control_q[`BKREG_CTL_STBY_EN];
    end else begin
      buck2_on_d = control_q[`BKREG_CTL_RUN_EN];
    end
  end

  // ============================================================
  // regulator control outputs, all registered
  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fuse_load_done                <= 1'b0;
      buck2_sleep_voltage_code      <= 6'h00;
      buck2_on                      <= 1'b0;
      buck2_low_power_select        <= 1'b0;
      buck2_slew_select             <= `BKREG_SLEW_FAST_RST;
      buck2_forced_pwm_on_ramp_down <= 1'b0;
      buck2_forced_pwm              <= 1'b0;
      buck2_discharge_on            <= 1'b0;
      buck2_current_limit           <= 2'h0;
      buck2_timing_method           <= 1'b0;
      buck3_run_voltage_code        <= 4'h0;
    end else begin
      fuse_load_done           <= booted;
      buck2_sleep_voltage_code <= sleepv_q;
      buck2_on                 <= buck2_on_d;
      // low power only outside run mode
      buck2_low_power_select <= control_q[`BKREG_CTL_LOW_POWER] &
                                (in_sleep | in_standby);
      // fuse option overrides: slew forced to the fast setting
      buck2_slew_select <= scaling_fuse ? `BKREG_SLEW_FAST_RST :
                           control_q[`BKREG_CTL_SLEW];
      buck2_forced_pwm_on_ramp_down <= control_q[`BKREG_CTL_FORCED_PULSE_WIDTH_RAMP];
      buck2_forced_pwm              <= control_q[`BKREG_CTL_FORCED_PULSE_WIDTH];
      // resistor only while the regulator is off and discharge allowed;
      // taken from the same next enable, so the two never overlap
      buck2_discharge_on <= ~control_q[`BKREG_CTL_DISCH_DIS] & ~buck2_on_d;
      buck2_current_limit    <= ilim_q;
      buck2_timing_method    <= tmode_q;
      buck3_run_voltage_code <= b3volt_q;
    end
  end

endmodule

// File: testbench/bkreg_chk.sv
// concurrent checks on the ports of the buck register slice
`timescale 1ns/1ps

// ============================================================
// checker module
module bkreg_chk (
  input logic       clk,
  input logic       rst_n,
  input logic [7:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       fuse_scaling_select,
  input logic       mode_standby,
  input logic       mode_sleep,
  input logic       fuse_load_done,
  input logic       buck2_on,
  input logic       buck2_low_power_select,
  input logic       buck2_slew_select,
  input logic       buck2_forced_pwm,
  input logic       buck2_discharge_on,
  input logic [1:0] buck2_current_limit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // read data is zero unless a read strobe came one cycle before
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without a read strobe");
  limit_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h3c |->
    (reg_rdata & 8'hec) == 8'h00) else $error("unused limit bits read nonzero");
  sleep_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h3a |->
    reg_rdata[7:6] == 2'b00) else $error("unused sleep code bits read nonzero");
  buck3_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h3e |->
    reg_rdata[7:4] == 4'h0) else $error("unused buck3 bits read nonzero");
  // four cycles cover the two sync flops, the output flop and the sampling edge
  slew_ignored_a: assert property (fuse_scaling_select [*4] |-> !buck2_slew_select)
    else $error("slew select used while fuse option set");
  low_power_mode_a: assert property ((!mode_standby && !mode_sleep) [*4] |->
    !buck2_low_power_select) else $error("low power outside standby or sleep");
  // discharge and enable come from one next value, never both high
  discharge_off_a: assert property (buck2_discharge_on |-> !buck2_on)
    else $error("discharge connected while regulator enabled");
  forced_pulse_width_by_write_a: assert property (fuse_load_done && $past(fuse_load_done, 2) &&
    $changed(buck2_forced_pwm) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h3b)
    else $error("forced pwm changed without a control write");
  ilim_by_write_a: assert property (fuse_load_done && $past(fuse_load_done, 2) &&
    $changed(buck2_current_limit) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h3c)
    else $error("current limit changed without a limit write");

  // main scenarios reached
  cover property ($past(reg_rd) && $past(reg_addr) == 8'h3b);
  cover property (fuse_scaling_select && buck2_low_power_select);
  cover property (buck2_discharge_on);
endmodule

bind bkreg_top bkreg_chk u_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fuse_scaling_select(fuse_scaling_select),
  .mode_standby(mode_standby), .mode_sleep(mode_sleep), .fuse_load_done(fuse_load_done),
  .buck2_on(buck2_on), .buck2_low_power_select(buck2_low_power_select),
  .buck2_slew_select(buck2_slew_select), .buck2_forced_pwm(buck2_forced_pwm),
  .buck2_discharge_on(buck2_discharge_on), .buck2_current_limit(buck2_current_limit)
);

// File: testbench/tb_top.sv
// self-checking testbench for the buck register slice
`timescale 1ns/1ps

module tb_top;
  // ============================================================
  // signals
  logic       clk, rst_n, reg_wr, reg_rd, fuse_prog_we, fuse_load_done;
  logic       fuse_scaling_select, mode_standby, mode_sleep, buck2_timing_method;
  logic       buck2_on, buck2_low_power_select, buck2_slew_select, buck2_discharge_on;
  logic       buck2_forced_pwm_on_ramp_down, buck2_forced_pwm;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fuse_prog_data, rd_val, fctl, flim, fb3, w;
  logic [1:0] fuse_prog_addr, buck2_current_limit;
  logic [5:0] buck2_run_voltage_code, buck2_sleep_voltage_code;
  logic [3:0] buck3_run_voltage_code;
  integer     seed, fail_count, samples_checked, i, n;

  bkreg_top uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuse_prog_we(fuse_prog_we),
    .fuse_prog_addr(fuse_prog_addr), .fuse_prog_data(fuse_prog_data),
    .fuse_scaling_select(fuse_scaling_select), .buck2_run_voltage_code(buck2_run_voltage_code),
    .mode_standby(mode_standby), .mode_sleep(mode_sleep), .fuse_load_done(fuse_load_done),
    .buck2_sleep_voltage_code(buck2_sleep_voltage_code), .buck2_on(buck2_on),
    .buck2_low_power_select(buck2_low_power_select), .buck2_slew_select(buck2_slew_select),
    .buck2_forced_pwm_on_ramp_down(buck2_forced_pwm_on_ramp_down),
    .buck2_forced_pwm(buck2_forced_pwm), .buck2_discharge_on(buck2_discharge_on),
    .buck2_current_limit(buck2_current_limit), .buck2_timing_method(buck2_timing_method),
    .buck3_run_voltage_code(buck3_run_voltage_code)
  );

  // ============================================================
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ============================================================
  // tasks and expectations
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one-cycle strobes; the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic fuse(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    fuse_prog_we   <= 1'b1;
    fuse_prog_addr <= a;
    fuse_prog_data <= d;
    @(posedge clk);
    fuse_prog_we   <= 1'b0;
  endtask

  // wait for the fuse copy after a reset, then read back the fuse defaults;
  // a zero fuse word makes the sleep code take a copy of the run code
  task automatic boot_checks;
    n = 0;
    while (fuse_load_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n = n + 1;
    end
    if (fuse_load_done !== 1'b1) begin
      check("fuse load done", {7'h00, fuse_load_done}, 8'h01);
      summarize();
    end
    rd(8'h3a);
    check("sleep code", rd_val, {2'b00, buck2_run_voltage_code});
    rd(8'h3b);
    check("control", rd_val, fctl);
    rd(8'h3c);
    check("limit", rd_val, {6'h00, flim[1:0]});
    rd(8'h3e);
    check("buck3 code", rd_val, {4'h0, fb3[3:0]});
    check("buck3 out", {4'h0, buck3_run_voltage_code}, {4'h0, fb3[3:0]});
  endtask

  // regulator outputs for a control byte, mode pins and fuse option
  function automatic logic [5:0] exp_reg(input logic [7:0] c, input logic sb, input logic sl,
                                         input logic fs);
    logic on;
    on = sl ? c[2] : (sb ? c[1] : c[0]);
    return {on, c[3] & (sb | sl), c[4] & ~fs, c[5], c[6], ~c[7] & ~on};
  endfunction

  // ============================================================
  // main sequence
  initial begin
    seed = 32'h46fc;
    fail_count = 0;
    samples_checked = 0;
    {rst_n, reg_wr, reg_rd, fuse_prog_we, fuse_scaling_select, mode_standby, mode_sleep} = 0;
    {reg_addr, reg_wdata, fuse_prog_addr, fuse_prog_data} = 0;
    buck2_run_voltage_code = $random(seed);
    fctl = $random(seed);
    flim = $random(seed);
    fb3 = $random(seed);
    // fuses survive reset, so they are written while reset is held
    fuse(2'h0, 8'h00);
    fuse(2'h1, fctl);
    fuse(2'h2, flim);
    fuse(2'h3, fb3);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    boot_checks();
    // control byte against every mode and fuse option combination
    for (i = 0; i < 32; i = i + 1) begin
      // all ones in every mode and fuse option, then all zeros in every mode with the fuse option clear, then random
      w = (i < 8) ? 8'hff : (i < 12) ? 8'h00 : $random(seed);
      @(posedge clk);
      mode_standby        <= i[0];
      mode_sleep          <= i[1];
      fuse_scaling_select <= i[2];
      wr(8'h3b, w);
      repeat (6) @(posedge clk);
      #1 check("regulator", {2'b00, buck2_on, buck2_low_power_select, buck2_slew_select,
        buck2_forced_pwm_on_ramp_down, buck2_forced_pwm, buck2_discharge_on},
        {2'b00, exp_reg(w, i[0], i[1], i[2])});
      rd(8'h3b);
      check("control readback", rd_val, w);
    end
    // limit and sleep registers, unused bits set; an unmapped write between
    for (i = 0; i < 12; i = i + 1) begin
      w = (i < 4) ? {3'h7, i[0], 2'h3, i[1:0]} : $random(seed);
      wr(8'h3c, w);
      wr(8'h3a, w);
      wr(8'h3d, ~w);
      rd(8'h3c);
      check("limit readback", rd_val, w & 8'h13);
      rd(8'h3a);
      check("sleep readback", rd_val, w & 8'h3f);
      rd(8'h3d);
      check("unmapped read", rd_val, 8'h00);
      check("limit out", {5'h00, buck2_timing_method, buck2_current_limit},
        {5'h00, w[4], w[1:0]});
      check("sleep out", {2'b00, buck2_sleep_voltage_code}, w & 8'h3f);
    end
    // a second reset mid-run: software values go, fuse values come back
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    boot_checks();
    summarize();
  end
endmodule
